//--- src/evss_consts.svh
`ifndef EVSS_CONSTS_SVH
`define EVSS_CONSTS_SVH
// register offsets
`define EVSS_OFS_CTRL       8'h00
`define EVSS_OFS_STAT       8'h04
`define EVSS_OFS_MASK       8'h08
`define EVSS_OFS_PSW        8'h0c
`define EVSS_OFS_GSR        8'h10
`define EVSS_OFS_LAST       8'h14
// control register fields
`define EVSS_CTRL_W         13
`define EVSS_CTRL_BERR_LSB  0
`define EVSS_CTRL_TMR_BIT   5
`define EVSS_CTRL_CSTOR_LSB 6
`define EVSS_CTRL_CSTOR_EN  11
`define EVSS_CTRL_RISC_BIT  12
`define EVSS_CTRL_RST       13'h0518
// status and mask bits
`define EVSS_ST_W           4
`define EVSS_ST_DISP        0
`define EVSS_ST_REJ         1
`define EVSS_ST_RFLT        2
`define EVSS_ST_DROP        3
`define EVSS_MASK_RST       4'h0
`define EVSS_GSR_RST        32'h0000_0000
// vector slots
`define EVSS_VEC_BERR       11'h050
`define EVSS_BERR_SEL_MAX   8'h04
`define EVSS_VEC_SOFT       11'h080
`define EVSS_VEC_TIMER      11'h0c0
`define EVSS_VEC_EMUL_NEW   11'h0c8
`define EVSS_VEC_EMUL_RES   11'h0cc
`define EVSS_VEC_CSTOR_RX   11'h0f0
`define EVSS_VEC_CSTOR_TX   11'h0f4
`define EVSS_VEC_CTERM_RX   11'h0f8
`define EVSS_VEC_CTERM_TX   11'h0fc
`define EVSS_VEC_ADAPT      11'h100
`define EVSS_VEC_DEV        11'h200
`define EVSS_VEC_DEV2       11'h400
`define EVSS_DEV2_SEL_MAX   7'h7b
// priority levels
`define EVSS_IPL_NONE       5'h00
`define EVSS_IPL_14         5'h14
`define EVSS_IPL_16         5'h16
`define EVSS_IPL_17         5'h17
`define EVSS_IPL_18         5'h18
// stack slot of the interrupt service context
`define EVSS_SLOT_IS        3'h4
`endif

//--- src/evss_pkg.sv
package evss_pkg;
  // event source groups
  typedef enum logic [3:0] {
    EVSS_K_BERR, EVSS_K_SOFT, EVSS_K_TIMER, EVSS_K_EMUL, EVSS_K_CSTOR_RX, EVSS_K_CSTOR_TX,
    EVSS_K_CTERM_RX, EVSS_K_CTERM_TX, EVSS_K_ADAPT, EVSS_K_DEV
  } evss_kind_e;
  // one event request from the core
  typedef struct packed {
    evss_kind_e  kind;
    logic [7:0]  sel;
    logic [4:0]  interrupt_priority_level;
    logic        first_part_done;
    logic [1:0]  code;
  } evss_req_s;
  // stack status bits of the status word
  typedef struct packed {
    logic        is;
    logic [1:0]  mode;
  } evss_psw_s;
  // dispatch result
  typedef struct packed {
    logic [10:0] vector;
    logic [4:0]  interrupt_priority_level;
    logic        on_is;
  } evss_disp_s;
  typedef enum logic [1:0] {EVSS_S_IDLE, EVSS_S_SAVE, EVSS_S_READ, EVSS_S_LOAD} evss_state_e;
  typedef logic [2:0] evss_slot_t;
endpackage

//--- src/evss_prio_map.sv
`timescale 1ns/1ps
`include "evss_consts.svh"
module evss_prio_map
  import evss_pkg::*;
(
  input  wire evss_req_s  req_i,
  input  wire logic [4:0] berr_ipl_i,
  input  wire logic       tmr_hi_i,
  input  wire logic [4:0] cstor_ipl_i,
  input  wire logic       cstor_en_i,
  input  wire logic       risc_en_i,
  output logic [10:0]     vector_o,
  output logic [4:0]      ipl_o,
  output logic            legal_o
);
  // named slot offsets for indexed groups
  wire [10:0] berr_vec  = `EVSS_VEC_BERR + {6'h00, req_i.sel[2:0], 2'b00};
  wire [10:0] soft_vec  = `EVSS_VEC_SOFT + {5'h00, req_i.sel[3:0], 2'b00};
  wire [10:0] adapt_vec = `EVSS_VEC_ADAPT + {3'b000, req_i.sel[5:0], 2'b00};
  wire [10:0] dev_vec   = (req_i.sel[7] ? `EVSS_VEC_DEV2 : `EVSS_VEC_DEV) + {2'b00, req_i.sel[6:0], 2'b00};
  wire       dev_ok    = req_i.sel[7] ? (req_i.sel[6:0] <= `EVSS_DEV2_SEL_MAX) && (req_i.interrupt_priority_level != `EVSS_IPL_NONE)
                                      : (req_i.interrupt_priority_level >= `EVSS_IPL_14) && (req_i.interrupt_priority_level <= `EVSS_IPL_17);
  // decode of vector, level and legality per group
  always_comb
  begin
    vector_o = 11'h000;
    ipl_o    = `EVSS_IPL_NONE;
    legal_o  = 1'b1;
    unique case (req_i.kind)
      EVSS_K_BERR:     begin vector_o = berr_vec; ipl_o = berr_ipl_i; legal_o = req_i.sel <= `EVSS_BERR_SEL_MAX; end
      EVSS_K_SOFT:     begin vector_o = soft_vec; ipl_o = {1'b0, req_i.sel[3:0]};
                             legal_o = (req_i.sel[7:4] == 4'h0) && (req_i.sel[3:0] != 4'h0); end
      EVSS_K_TIMER:    begin vector_o = `EVSS_VEC_TIMER; ipl_o = tmr_hi_i ? `EVSS_IPL_18 : `EVSS_IPL_16; end
      EVSS_K_EMUL:     begin vector_o = req_i.first_part_done ? `EVSS_VEC_EMUL_RES : `EVSS_VEC_EMUL_NEW;
                             legal_o = risc_en_i; end
      EVSS_K_CSTOR_RX: begin vector_o = `EVSS_VEC_CSTOR_RX; ipl_o = cstor_ipl_i; legal_o = cstor_en_i; end
      EVSS_K_CSTOR_TX: begin vector_o = `EVSS_VEC_CSTOR_TX; ipl_o = cstor_ipl_i; legal_o = cstor_en_i; end
      EVSS_K_CTERM_RX: begin vector_o = `EVSS_VEC_CTERM_RX; ipl_o = `EVSS_IPL_14; end
      EVSS_K_CTERM_TX: begin vector_o = `EVSS_VEC_CTERM_TX; ipl_o = `EVSS_IPL_14; end
      EVSS_K_ADAPT:    begin vector_o = adapt_vec; ipl_o = `EVSS_IPL_14 | {3'b000, req_i.sel[5:4]};
                             legal_o = req_i.sel[7:6] == 2'b00; end
      EVSS_K_DEV:      begin vector_o = dev_vec; ipl_o = req_i.interrupt_priority_level; legal_o = dev_ok; end
      default:         legal_o = 1'b0;
    endcase
  end
endmodule

//--- src/evss_stack_bank.sv
`timescale 1ns/1ps
module evss_stack_bank
#(
  parameter int W = 32,
  parameter int N = 5
)
(
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  input  wire logic         wr_en_i,
  input  wire logic [2:0]   wr_addr_i,
  input  wire logic [W-1:0] wr_data_i,
  input  wire logic         rd_en_i,
  input  wire logic [2:0]   rd_addr_i,
  output logic [W-1:0]      rd_data_o
);
  generate
    if (N < 5 || N > 8)
    begin : g_chk
      $error("stack bank needs five to eight slots");
    end
  endgenerate
  // saved pointers, contents undefined until first save
  logic [W-1:0] mem [N];
  always_ff @(posedge clk_i)
  begin
    if (wr_en_i)
      mem[wr_addr_i] <= wr_data_i;
  end
  // registered read port
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rd_data_o <= '0;
    else if (rd_en_i)
      rd_data_o <= mem[rd_addr_i];
  end
endmodule

//--- src/evss_top.sv
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "evss_consts.svh"
// Overview of operation
// - bus and memory error events use slots 50 to 60 at a configured level.
// - software levels 1 to F dispatch through slots 84 to BC in order.
// - interval timer uses slot C0 at level 16 or 18 hex.
// - reduced-set builds trap through C8 for a fresh emulated instruction.
// - reduced-set builds fault through CC for a resumed emulated instruction.
// - console storage receive and transmit use F0, F4, optional, configured level.
// - always exactly one context: per-process or interrupt service.
// - per-process context uses one of four modes with stack indicator zero.
// - interrupt service context runs kernel mode with stack indicator one.
// - one saved stack pointer for each of the five states.
// - on state change save the stack register, then load the new pointer.
// - four process pointers live in the process control block slots; the stack bank holds them in its slots 0 to 3 instead.
// - vector code 1 uses interrupt stack; code 0 kernel unless already there.
// - stack indicator and mode select which saved pointer is active.
// - nonzero mode with indicator set never held; such returns fault.
module evss_top
  import evss_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 8
)
(
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              req_valid_i,
  input  wire evss_req_s         req_i,
  input  wire logic              ret_valid_i,
  input  wire evss_psw_s         ret_psw_i,
  input  wire logic              gsr_wr_i,
  input  wire logic [DATA_W-1:0] gsr_wdata_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic [DATA_W-1:0]      reg_rdata_o,
  output logic                   busy_o,
  output logic                   disp_valid_o,
  output evss_disp_s             disp_o,
  output logic                   req_reject_o,
  output logic                   ret_fault_o,
  output evss_psw_s              psw_o,
  output logic [DATA_W-1:0]      gsr_o,
  output logic                   irq_o
);
  generate
    if (DATA_W != 32 || ADDR_W < 5)
    begin : g_chk
      $error("event dispatch needs 32-bit data and at least 5 address bits");
    end
  endgenerate

  // registers
  evss_state_e             state_reg, state_next;
  evss_psw_s               psw_reg;
  evss_disp_s              disp_reg;
  evss_slot_t              old_slot_reg;
  logic                    take_pend_reg;
  logic                    disp_valid_reg;
  logic                    reject_reg;
  logic                    rflt_reg;
  logic                    busy_reg;
  logic                    irq_reg;
  logic [DATA_W-1:0]       gsr_reg;
  logic [DATA_W-1:0]       rdata_reg;
  logic [`EVSS_CTRL_W-1:0] ctrl_reg;
  logic [`EVSS_ST_W-1:0]   stat_reg, stat_next;
  logic [`EVSS_ST_W-1:0]   mask_reg;
  logic [DATA_W-1:0]       bank_rdata;

  // stack slot of a status word: one of exactly five states
  function automatic evss_slot_t slot_of(input evss_psw_s p);
    slot_of = p.is ? `EVSS_SLOT_IS : {1'b0, p.mode};
  endfunction

  // vector and level decode
  logic [10:0] map_vector;
  logic [4:0] map_ipl;
  logic       map_legal;
  evss_prio_map u_map (
    .req_i       (req_i),
    .berr_ipl_i  (ctrl_reg[`EVSS_CTRL_BERR_LSB +: 5]),
    .tmr_hi_i    (ctrl_reg[`EVSS_CTRL_TMR_BIT]),
    .cstor_ipl_i (ctrl_reg[`EVSS_CTRL_CSTOR_LSB +: 5]),
    .cstor_en_i  (ctrl_reg[`EVSS_CTRL_CSTOR_EN]),
    .risc_en_i   (ctrl_reg[`EVSS_CTRL_RISC_BIT]),
    .vector_o    (map_vector),
    .ipl_o       (map_ipl),
    .legal_o     (map_legal)
  );

  // request and return acceptance
  wire idle      = state_reg == EVSS_S_IDLE;
  wire req_seen  = req_valid_i && idle;
  wire take_ok   = req_seen && map_legal && !req_i.code[1];
  wire ret_seen  = ret_valid_i && !req_valid_i && idle;
  wire ret_bad   = ret_psw_i.is && (ret_psw_i.mode != 2'b00);
  wire ret_ok    = ret_seen && !ret_bad;
  wire dropped   = (req_valid_i || ret_valid_i) && !idle;
  wire start     = take_ok || ret_ok;

  // new status word: taking an event clears mode, code 1 or current IS keeps IS
  wire        take_is  = psw_reg.is || (req_i.code == 2'b01);
  evss_psw_s  take_psw;
  assign take_psw = '{is: take_is, mode: 2'b00};
  evss_psw_s  tgt_psw;
  assign tgt_psw  = take_ok ? take_psw : ret_psw_i;
  wire changing   = slot_of(tgt_psw) != slot_of(psw_reg);

  // stack bank: four process slots plus interrupt slot
  wire bank_wr = state_reg == EVSS_S_SAVE;
  wire bank_rd = state_reg == EVSS_S_READ;
  evss_stack_bank #(.W(DATA_W), .N(5)) u_bank (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .wr_en_i   (bank_wr),
    .wr_addr_i (old_slot_reg),
    .wr_data_i (gsr_reg),
    .rd_en_i   (bank_rd),
    .rd_addr_i (slot_of(psw_reg)),
    .rd_data_o (bank_rdata)
  );

  // swap sequencer
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      EVSS_S_IDLE: if (start && changing) state_next = EVSS_S_SAVE;
      EVSS_S_SAVE: state_next = EVSS_S_READ;
      EVSS_S_READ: state_next = EVSS_S_LOAD;
      EVSS_S_LOAD: state_next = EVSS_S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state_reg <= EVSS_S_IDLE;
    else
      state_reg <= state_next;
  end

  // status word and pending take
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      psw_reg       <= '{is: 1'b1, mode: 2'b00};
      old_slot_reg  <= `EVSS_SLOT_IS;
      take_pend_reg <= 1'b0;
    end
    else if (start)
    begin
      psw_reg       <= tgt_psw;
      old_slot_reg  <= slot_of(psw_reg);
      take_pend_reg <= take_ok;
    end
  end

  // general stack register: core writes when idle, loaded at end of swap
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      gsr_reg <= `EVSS_GSR_RST;
    else if (state_reg == EVSS_S_LOAD)
      gsr_reg <= bank_rdata;
    else if (gsr_wr_i && idle)
      gsr_reg <= gsr_wdata_i;
  end

  // dispatch result, one-cycle pulses and busy flag
  wire disp_fire = (take_ok && !changing) || (state_reg == EVSS_S_LOAD && take_pend_reg);
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      disp_reg       <= '0;
      disp_valid_reg <= 1'b0;
      reject_reg     <= 1'b0;
      rflt_reg       <= 1'b0;
      busy_reg       <= 1'b0;
    end
    else
    begin
      if (take_ok)
        disp_reg <= '{vector: map_vector, interrupt_priority_level: map_ipl, on_is: take_is};
      disp_valid_reg <= disp_fire;
      reject_reg     <= req_seen && !take_ok;
      rflt_reg       <= ret_seen && ret_bad;
      busy_reg       <= state_next != EVSS_S_IDLE;
    end
  end

  // register decode
  wire [ADDR_W-1:0] a_ctrl = ADDR_W'(`EVSS_OFS_CTRL);
  wire [ADDR_W-1:0] a_stat = ADDR_W'(`EVSS_OFS_STAT);
  wire [ADDR_W-1:0] a_mask = ADDR_W'(`EVSS_OFS_MASK);
  wire [ADDR_W-1:0] a_psw  = ADDR_W'(`EVSS_OFS_PSW);
  wire [ADDR_W-1:0] a_gsr  = ADDR_W'(`EVSS_OFS_GSR);
  wire [ADDR_W-1:0] a_last = ADDR_W'(`EVSS_OFS_LAST);
  wire wr_ctrl = reg_wr_i && (reg_addr_i == a_ctrl);
  wire wr_mask = reg_wr_i && (reg_addr_i == a_mask);
  wire rd_stat = reg_rd_i && (reg_addr_i == a_stat);

  // sticky events, a status read clears, a new event wins
  wire [`EVSS_ST_W-1:0] stat_set = {dropped, ret_seen && ret_bad, req_seen && !take_ok, disp_fire};
  assign stat_next = (rd_stat ? '0 : stat_reg) | stat_set;
  wire [`EVSS_ST_W-1:0] mask_next = wr_mask ? reg_wdata_i[`EVSS_ST_W-1:0] : mask_reg;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_reg <= `EVSS_CTRL_RST;
      stat_reg <= '0;
      mask_reg <= `EVSS_MASK_RST;
      irq_reg  <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= reg_wdata_i[`EVSS_CTRL_W-1:0];
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      irq_reg  <= |(stat_next & mask_next);
    end
  end

  // read mux, unmapped reads return zero
  wire [DATA_W-1:0] rd_mux =
    (reg_addr_i == a_ctrl) ? {{(DATA_W-`EVSS_CTRL_W){1'b0}}, ctrl_reg} :
    (reg_addr_i == a_stat) ? {{(DATA_W-`EVSS_ST_W){1'b0}}, stat_reg} :
    (reg_addr_i == a_mask) ? {{(DATA_W-`EVSS_ST_W){1'b0}}, mask_reg} :
    (reg_addr_i == a_psw)  ? {{(DATA_W-3){1'b0}}, psw_reg} :
    (reg_addr_i == a_gsr)  ? gsr_reg :
    (reg_addr_i == a_last) ? {{(DATA_W-17){1'b0}}, disp_reg} : '0;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rdata_reg <= '0;
    else
      rdata_reg <= reg_rd_i ? rd_mux : '0;
  end

  // outputs straight from flip-flops
  assign reg_rdata_o  = rdata_reg;
  assign busy_o       = busy_reg;
  assign disp_valid_o = disp_valid_reg;
  assign disp_o       = disp_reg;
  assign req_reject_o = reject_reg;
  assign ret_fault_o  = rflt_reg;
  assign psw_o        = psw_reg;
  assign gsr_o        = gsr_reg;
  assign irq_o        = irq_reg;

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_swap;
    state_reg == EVSS_S_SAVE ##1 state_reg == EVSS_S_READ ##1 state_reg == EVSS_S_LOAD ##1 idle;
  endsequence

  property p_psw_legal;
    psw_reg.is |-> psw_reg.mode == 2'b00;
  endproperty
  a_psw_legal: assert property (p_psw_legal) else $error("mode set on interrupt stack");

  property p_ret_fault;
    (ret_seen && ret_bad) |=> ret_fault_o && $stable(psw_o) && !busy_o;
  endproperty
  a_ret_fault: assert property (p_ret_fault) else $error("bad return not faulted");

  property p_take_kernel;
    take_ok |=> psw_o.mode == 2'b00 && (psw_o.is == $past(take_is));
  endproperty
  a_take_kernel: assert property (p_take_kernel) else $error("taken event left wrong mode");

  property p_code_one;
    (take_ok && req_i.code == 2'b01) |=> psw_o.is;
  endproperty
  a_code_one: assert property (p_code_one) else $error("code 1 not on interrupt stack");

  property p_code_zero;
    (take_ok && req_i.code == 2'b00 && !psw_o.is) |=> !psw_o.is;
  endproperty
  a_code_zero: assert property (p_code_zero) else $error("code 0 left kernel stack");

  property p_swap_seq;
    (idle && start && changing) |=> s_swap;
  endproperty
  a_swap_seq: assert property (p_swap_seq) else $error("stack swap sequence broken");

  property p_gsr_load;
    state_reg == EVSS_S_LOAD |=> gsr_o == $past(bank_rdata);
  endproperty
  a_gsr_load: assert property (p_gsr_load) else $error("stack register not reloaded");

  property p_soft_ipl;
    disp_valid_o && disp_o.vector >= 11'h084 && disp_o.vector <= 11'h0bc
      |-> disp_o.interrupt_priority_level == {3'b000, disp_o.vector[5:2]} - 5'h00;
  endproperty
  a_soft_ipl: assert property (p_soft_ipl) else $error("software level mismatch");

  property p_timer_ipl;
    disp_valid_o && disp_o.vector == `EVSS_VEC_TIMER |-> disp_o.interrupt_priority_level inside {`EVSS_IPL_16, `EVSS_IPL_18};
  endproperty
  a_timer_ipl: assert property (p_timer_ipl) else $error("timer level wrong");

  property p_adapt_ipl;
    disp_valid_o && disp_o.vector[10:8] == 3'b001 |-> disp_o.interrupt_priority_level == (`EVSS_IPL_14 | {3'b000, disp_o.vector[7:6]});
  endproperty
  a_adapt_ipl: assert property (p_adapt_ipl) else $error("adapter level wrong");

  property p_dev_ipl;
    disp_valid_o && disp_o.vector[10:9] == 2'b01
      |-> disp_o.interrupt_priority_level >= `EVSS_IPL_14 && disp_o.interrupt_priority_level <= `EVSS_IPL_17;
  endproperty
  a_dev_ipl: assert property (p_dev_ipl) else $error("device level out of range");

  property p_disp_bound;
    take_ok |-> ##[1:4] disp_valid_o;
  endproperty
  a_disp_bound: assert property (p_disp_bound) else $error("dispatch not issued in time");
endmodule

//--- dv/evss_core_model.sv
`timescale 1ns/1ps
module evss_core_model
  import evss_pkg::*;
(
  input  wire logic   clk_i,
  output logic        req_valid_o,
  output evss_req_s   req_o,
  output logic        ret_valid_o,
  output evss_psw_s   ret_psw_o,
  output logic        gsr_wr_o,
  output logic [31:0] gsr_wdata_o
);
  // customary software levels for trap delivery and scheduling
  localparam logic [7:0] AST_LVL   = 8'h02;
  localparam logic [7:0] SCHED_LVL = 8'h03;
  // quiet lines at time zero
  initial
  begin
    req_valid_o = 1'b0;
    req_o       = '0;
    ret_valid_o = 1'b0;
    ret_psw_o   = '0;
    gsr_wr_o    = 1'b0;
    gsr_wdata_o = '0;
  end
  // one event request, qualifiers scrambled on release
  task automatic send_req(input evss_kind_e k, input logic [7:0] s, input logic [4:0] l,
                          input logic f, input logic [1:0] c, input int gap);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    req_valid_o <= 1'b1;
    req_o       <= '{k, s, l, f, c};
    @(posedge clk_i);
    req_valid_o <= 1'b0;
    req_o       <= evss_req_s'(~req_o);
  endtask
  // one return loading a status word
  task automatic send_ret(input evss_psw_s p);
    @(posedge clk_i);
    ret_valid_o <= 1'b1;
    ret_psw_o   <= p;
    @(posedge clk_i);
    ret_valid_o <= 1'b0;
    ret_psw_o   <= evss_psw_s'(~ret_psw_o);
  endtask
  // core write of the stack register
  task automatic write_gsr(input logic [31:0] d);
    @(posedge clk_i);
    gsr_wr_o    <= 1'b1;
    gsr_wdata_o <= d;
    @(posedge clk_i);
    gsr_wr_o    <= 1'b0;
    gsr_wdata_o <= ~gsr_wdata_o;
  endtask
endmodule

//--- dv/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module testbench
  import evss_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic        busy_o;
  logic        disp_valid_o;
  evss_disp_s  disp_o;
  logic        req_reject_o;
  logic        ret_fault_o;
  evss_psw_s   psw_o;
  logic [31:0] gsr_o;
  logic        irq_o;
  logic        req_valid;
  evss_req_s   req;
  logic        ret_valid;
  evss_psw_s   ret_psw;
  logic        gsr_wr;
  logic [31:0] gsr_wdata;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cyc = 0;

  // clock and hang guard
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      finish_test();
    end
  end

  evss_core_model u_core (.clk_i(clk_i), .req_valid_o(req_valid), .req_o(req), .ret_valid_o(ret_valid),
    .ret_psw_o(ret_psw), .gsr_wr_o(gsr_wr), .gsr_wdata_o(gsr_wdata));
  evss_top u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid), .req_i(req),
    .ret_valid_i(ret_valid), .ret_psw_i(ret_psw), .gsr_wr_i(gsr_wr), .gsr_wdata_i(gsr_wdata),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .busy_o(busy_o), .disp_valid_o(disp_valid_o), .disp_o(disp_o),
    .req_reject_o(req_reject_o), .ret_fault_o(ret_fault_o), .psw_o(psw_o), .gsr_o(gsr_o), .irq_o(irq_o));

  // verdict and end of run
  task automatic finish_test();
    if (error_cnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // register bus cycles
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
    #1;
  endtask
  task automatic reg_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    `CHK(reg_rdata_o, e);
  endtask
  // bounded wait for a stack swap to end
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy_o !== 1'b0 && n < 8)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    `CHK(busy_o, 1'b0);
  endtask
  // one event with its expected dispatch or refusal
  task automatic ev(input evss_kind_e k, input logic [7:0] s, input logic [4:0] l, input logic f,
                    input logic [1:0] c, input logic [10:0] v, input logic [4:0] p, input logic on, input logic rej);
    u_core.send_req(k, s, l, f, c, 0);
    #1;
    `CHK(req_reject_o, rej);
    wait_idle();
    `CHK(disp_valid_o, !rej);
    if (!rej)
    begin
      `CHK(disp_o, {v, p, on});
    end
  endtask
  // one return with its expected fault or new status word
  task automatic rt(input logic is, input logic [1:0] m, input logic flt);
    u_core.send_ret('{is, m});
    #1;
    `CHK(ret_fault_o, flt);
    wait_idle();
    if (!flt)
    begin
      `CHK(psw_o, {is, m});
    end
  endtask

  // main sequence
  initial
  begin
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    #1;
    `CHK(psw_o, 3'b100);
    reg_chk(8'h00, 32'h0000_0518);
    reg_chk(8'h08, 32'h0);
    reg_wr(8'h0c, 32'h3);
    reg_chk(8'h0c, 32'h4);
    reg_chk(8'h20, 32'h0);
    for (int i = 0; i < 6; i++) ev(EVSS_K_BERR, i[7:0], 5'h0, 0, 0, 11'h050 + 11'(4 * i), 5'h18, 1, i == 5);
    for (int i = 0; i < 16; i++) ev(EVSS_K_SOFT, i[7:0], i[4:0], 0, 0, 11'h080 + 11'(4 * i), i[4:0], 1, i == 0);
    ev(EVSS_K_SOFT, u_core.AST_LVL, 5'h02, 0, 0, 11'h088, 5'h02, 1, 0);
    ev(EVSS_K_TIMER, 0, 0, 0, 0, 11'h0c0, 5'h16, 1, 0);
    ev(EVSS_K_EMUL, 0, 0, 0, 0, 11'h0c8, 5'h0, 1, 1);
    ev(EVSS_K_CSTOR_RX, 0, 0, 0, 0, 11'h0f0, 5'h14, 1, 1);
    reg_wr(8'h00, 32'h0000_1d38);
    ev(EVSS_K_TIMER, 0, 0, 0, 0, 11'h0c0, 5'h18, 1, 0);
    ev(EVSS_K_EMUL, 0, 0, 0, 0, 11'h0c8, 5'h0, 1, 0);
    ev(EVSS_K_EMUL, 0, 0, 1, 0, 11'h0cc, 5'h0, 1, 0);
    ev(EVSS_K_CSTOR_RX, 0, 0, 0, 0, 11'h0f0, 5'h14, 1, 0);
    ev(EVSS_K_CSTOR_TX, 0, 0, 0, 0, 11'h0f4, 5'h14, 1, 0);
    ev(EVSS_K_CTERM_RX, 0, 0, 0, 0, 11'h0f8, 5'h14, 1, 0);
    ev(EVSS_K_CTERM_TX, 0, 0, 0, 0, 11'h0fc, 5'h14, 1, 0);
    for (int i = 0; i < 64; i++) ev(EVSS_K_ADAPT, i[7:0], 0, 0, 0, 11'h100 + 11'(4 * i), 5'h14 + 5'(i[5:4]), 1, 0);
    for (int i = 0; i < 128; i++) ev(EVSS_K_DEV, i[7:0], 5'h14 + 5'(i[1:0]), 0, 0, 11'h200 + 11'(4 * i), 5'h14 + 5'(i[1:0]), 1, 0);
    ev(EVSS_K_DEV, 8'h00, 5'h13, 0, 0, 0, 0, 0, 1);
    for (int i = 0; i < 125; i++) ev(EVSS_K_DEV, 8'h80 + i[7:0], 5'h01 + 5'(i[3:0]), 0, 0, 11'h400 + 11'(4 * i), 5'h01 + 5'(i[3:0]), 1, i == 124);
    ev(EVSS_K_DEV, 8'h80, 5'h00, 0, 0, 0, 0, 0, 1);
    ev(EVSS_K_TIMER, 0, 0, 0, 2'h2, 0, 0, 0, 1);
    // one pointer per state, saved and reloaded across swaps
    u_core.write_gsr(32'h1500_0000);
    for (int m = 0; m < 4; m++)
    begin
      rt(0, m[1:0], 0);
      u_core.write_gsr(32'h1000_0000 + m);
    end
    ev(EVSS_K_BERR, 0, 0, 0, 2'h1, 11'h050, 5'h18, 1, 0);
    `CHK(psw_o, 3'b100);
    `CHK(gsr_o, 32'h1500_0000);
    for (int m = 0; m < 4; m++)
    begin
      rt(0, m[1:0], 0);
      `CHK(gsr_o, 32'h1000_0000 + m);
    end
    ev(EVSS_K_SOFT, u_core.SCHED_LVL, 5'h03, 0, 0, 11'h08c, 5'h03, 0, 0);
    `CHK(psw_o, 3'b000);
    `CHK(gsr_o, 32'h1000_0000);
    rt(1, 2'h2, 1);
    `CHK(psw_o, 3'b000);
    // sticky status, mask and the interrupt line
    reg_chk(8'h04, 32'h7);
    reg_wr(8'h08, 32'h1);
    ev(EVSS_K_TIMER, 0, 0, 0, 0, 11'h0c0, 5'h18, 0, 0);
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(irq_o, 1'b1);
    reg_chk(8'h04, 32'h1);
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(irq_o, 1'b0);
    ev(EVSS_K_TIMER, 0, 0, 0, 2'h3, 0, 0, 0, 1);
    repeat (2) @(posedge clk_i);
    #1;
    `CHK(irq_o, 1'b0);
    reg_chk(8'h04, 32'h2);
    // a request during a swap is dropped and flagged
    fork
      u_core.send_ret('{1'b0, 2'h1});
      u_core.send_req(EVSS_K_TIMER, 0, 0, 0, 0, 2);
    join
    #1;
    wait_idle();
    `CHK(psw_o, 3'b001);
    `CHK(gsr_o, 32'h1000_0001);
    reg_chk(8'h04, 32'h8);
    finish_test();
  end
endmodule
